// ---- rtl/acc_params.svh ----
// Constants of the comparator control block: register indices, field
// positions, reset values and synchroniser depth.
// Assumes it is included by bare name from each file that needs it.
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define ACC_IDX_DIG_IN_DIS 8'h01
`define ACC_IDX_CSR_A 8'h08
`define ACC_IDX_CSR_B 8'h09

// ==========================================================
// Control/status A field positions
`define ACC_A_PWR_OFF 7
`define ACC_A_BANDGAP 6
`define ACC_A_SYNC_OUT 5
`define ACC_A_FLAG 4
`define ACC_A_IRQ_EN 3
`define ACC_A_BORROW 2
`define ACC_A_MODE_HI 1
`define ACC_A_MODE_LO 0

// ==========================================================
// Control/status B field positions
`define ACC_B_HYST_EN 7
`define ACC_B_HYST_LVL 6
`define ACC_B_INSEL_HI 2
`define ACC_B_INSEL_LO 0

// ==========================================================
// Reset values and timing
`define ACC_RST_DIG_IN_DIS 8'h00
`define ACC_RST_CSR 8'h00
`define ACC_SYNC_STAGES 2
`define ACC_MAX_CHANNEL 6'h0A

`endif

// ---- rtl/acc_pkg.sv ----
// Types shared by the comparator control block.
// Assumes nothing of its surroundings.
package acc_pkg;
  // Edge mode of the flag event, codes fixed by the register layout
  typedef enum logic [1:0] {
    acc_mode_toggle = 2'h0,
    acc_mode_reserved = 2'h1,
    acc_mode_falling = 2'h2,
    acc_mode_rising = 2'h3
  } acc_irq_mode_type;
  // One register byte
  typedef logic [7:0] acc_byte_type;
endpackage

// ---- rtl/acc_mux_if.sv ----
// Carrier between the register side and the input selector.
// Assumes both ends run on one clock.
`timescale 1ns/1ps
`default_nettype none
interface acc_mux_if;
  logic cmp_mux_borrow_enable; // Software wants the converter mux
  logic converter_enable; // Converter running, blocks the borrow
  logic [5:0] converter_channel_select; // Converter channel code
  logic [2:0] cmp_input_select; // Dedicated pin pairing code
  logic cmp_bandgap_select; // Internal reference on positive side
  logic [2:0] pos_pin_sel_ff; // One-hot positive pin
  logic pos_bandgap_ff; // Reference drives positive side
  logic [2:0] neg_pin_sel_ff; // One-hot negative pin
  logic neg_from_conv_ff; // Converter mux drives negative side
  logic [5:0] neg_channel_ff; // Channel used on negative side
  modport ctrl (
    output cmp_mux_borrow_enable, converter_enable,
    output converter_channel_select, cmp_input_select, cmp_bandgap_select,
    input pos_pin_sel_ff, pos_bandgap_ff, neg_pin_sel_ff,
    input neg_from_conv_ff, neg_channel_ff
  );
  modport sel (
    input cmp_mux_borrow_enable, converter_enable,
    input converter_channel_select, cmp_input_select, cmp_bandgap_select,
    output pos_pin_sel_ff, pos_bandgap_ff, neg_pin_sel_ff,
    output neg_from_conv_ff, neg_channel_ff
  );
endinterface
`default_nettype wire

// ---- rtl/acc_sync.sv ----
// Multi-stage synchroniser for signals from outside the clock domain.
// Assumes the input may change at any time.
`timescale 1ns/1ps
`default_nettype none
module acc_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // ==========================================================
  // Flop chain
  logic [STAGES-1:0][WIDTH-1:0] chain_ff; // Only the next stage reads each
  // Shift one stage per clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chain_ff <= '0;
    end else begin
      chain_ff <= {chain_ff[STAGES-2:0], din};
    end
  end
  assign dout = chain_ff[STAGES-1];
endmodule
`default_nettype wire

// ---- rtl/acc_in_mux.sv ----
// Input selector of the comparator: which pin or channel feeds each side.
// Assumes the analog core follows the registered one-hot selects.
`timescale 1ns/1ps
`default_nettype none
module acc_in_mux (
  input wire logic hclk,
  input wire logic hresetn,
  acc_mux_if.sel mx
);
  import acc_pkg::*;
  logic borrowed; // Converter mux lends its output to the negative side
  logic [2:0] nxt_pos; // Next positive pin select
  logic [2:0] nxt_neg; // Next negative pin select
  assign borrowed = mx.cmp_mux_borrow_enable && !mx.converter_enable; //RULE_01

  // ==========================================================
  // Selection table
  always_comb begin
    nxt_pos = 3'h1;
    nxt_neg = 3'h2;
    if (borrowed) begin
      // Negative side from converter, field picks positive only
      nxt_neg = 3'h0; //RULE_04
      if (mx.cmp_input_select[2]) begin
        nxt_pos = 3'h4;
      end else if (mx.cmp_input_select[1]) begin
        nxt_pos = 3'h2;
      end else begin
        nxt_pos = 3'h1;
      end
    end else begin
      unique case (mx.cmp_input_select) //RULE_02 RULE_03
        3'h0: begin nxt_pos = 3'h1; nxt_neg = 3'h2; end
        3'h1: begin nxt_pos = 3'h1; nxt_neg = 3'h4; end
        3'h2: begin nxt_pos = 3'h2; nxt_neg = 3'h1; end
        3'h3: begin nxt_pos = 3'h2; nxt_neg = 3'h4; end
        3'h4: begin nxt_pos = 3'h4; nxt_neg = 3'h1; end
        default: begin nxt_pos = 3'h4; nxt_neg = 3'h2; end
      endcase
    end
    // Reference replaces whatever pin was chosen
    if (mx.cmp_bandgap_select) begin
      nxt_pos = 3'h0; //RULE_05
    end
  end

  // Registered selects keep glitches off the analog switches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mx.pos_pin_sel_ff <= 3'h1;
      mx.pos_bandgap_ff <= 1'b0;
      mx.neg_pin_sel_ff <= 3'h2;
      mx.neg_from_conv_ff <= 1'b0;
      mx.neg_channel_ff <= 6'h00;
    end else begin
      mx.pos_pin_sel_ff <= nxt_pos;
      mx.pos_bandgap_ff <= mx.cmp_bandgap_select; //RULE_05
      mx.neg_pin_sel_ff <= nxt_neg;
      mx.neg_from_conv_ff <= borrowed; //RULE_01
      mx.neg_channel_ff <= mx.converter_channel_select; //RULE_01
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  borrow_neg_a: assert property ( //RULE_01
    borrowed |=> mx.neg_from_conv_ff && mx.neg_pin_sel_ff == 3'h0
      && mx.neg_channel_ff == $past(mx.converter_channel_select))
    else $error("borrowed negative input not routed");
  dedicated_neg_a: assert property ( //RULE_02
    !borrowed |=> !mx.neg_from_conv_ff && $onehot(mx.neg_pin_sel_ff))
    else $error("dedicated negative pin not selected");
  pair_table_a: assert property ( //RULE_03
    (!borrowed && !mx.cmp_bandgap_select && mx.cmp_input_select == 3'h3)
      |=> mx.pos_pin_sel_ff == 3'h2 && mx.neg_pin_sel_ff == 3'h4)
    else $error("pin pair for code 3 wrong");
  borrow_pos_a: assert property ( //RULE_04
    (borrowed && !mx.cmp_bandgap_select && mx.cmp_input_select[2])
      |=> mx.pos_pin_sel_ff == 3'h4)
    else $error("positive pin under borrow wrong");
  bandgap_sub_a: assert property ( //RULE_05
    mx.cmp_bandgap_select |=> mx.pos_bandgap_ff && mx.pos_pin_sel_ff == 3'h0)
    else $error("reference not substituted");
  borrow_seen_c: cover property (borrowed ##1 mx.neg_from_conv_ff);
endmodule
`default_nettype wire

// ---- rtl/acc_top.sv ----
// Comparator control block: registers on AHB-Lite, input selection,
// output synchroniser, edge flag and interrupt request.
// Assumes one 100 MHz clock, single word transfers, and an analog core
// that follows the select, power and hysteresis outputs.
//
// How it works
// RULE_01: Borrowed converter channel feeds negative input
// RULE_02: Otherwise dedicated pin feeds negative input
// RULE_03: Input code selects positive/negative pin pair
// RULE_04: Under borrow, code selects positive pin only
// RULE_05: Reference bit replaces positive pin
// RULE_06: Power-off bit removes comparator power anytime
// RULE_07: Comparator output synchronised, one-two cycles late
// RULE_08: Matching output edge sets event flag
// RULE_09: Flag cleared by vector taken or write-one
// RULE_10: Request needs flag, enable and global enable
// RULE_11: Mode: toggle, reserved, falling, rising
// RULE_12: Software disables interrupt before mode/power change
// RULE_13: Hysteresis enable and level bits drive core
// RULE_14: Input-disable bit forces pin read to zero
// RULE_15: Edges from previous sample; reserved gives none
`include "acc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module acc_top (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Converter and processor context
  input wire logic converter_enable,
  input wire logic [5:0] converter_channel_select,
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  output logic irq,
  // Analog core
  input wire logic cmp_raw,
  output logic cmp_power_off,
  output logic hysteresis_enable,
  output logic hysteresis_level,
  output logic [2:0] pos_pin_sel,
  output logic pos_bandgap,
  output logic [2:0] neg_pin_sel,
  output logic neg_from_converter,
  output logic [5:0] neg_channel,
  // Digital input buffers of the shared pins
  input wire logic [7:0] pin_digital_in,
  output logic [7:0] pin_digital_read,
  output logic [7:0] digital_input_disable
);
  import acc_pkg::*;

  // ==========================================================
  // Register state
  acc_byte_type dig_in_dis_ff; // Digital input disable bits
  logic pwr_off_ff; // Comparator power removed
  logic bandgap_ff; // Reference on positive side
  logic flag_ff; // Sticky edge event
  logic irq_en_ff; // Interrupt enable, masks the request but not the flag
  logic borrow_ff; // Converter mux borrow request
  acc_irq_mode_type mode_ff; // Edge mode
  logic hyst_en_ff; // Hysteresis on
  logic hyst_lvl_ff; // Larger hysteresis level
  logic [2:0] insel_ff; // Dedicated pin code
  logic irq_ff; // Registered request
  acc_byte_type pin_read_ff; // Gated pin inputs

  // ==========================================================
  // Bus slave state
  logic wr_pend_ff; // Write data phase follows
  logic rd_wait_ff; // Read data phase, one wait state
  logic [31:0] addr_ff; // Address held for the data phase
  logic [31:0] hrdata_ff; // Read data register
  logic addr_take; // Valid address phase accepted
  logic wr_csr_a; // Write to control/status A this cycle
  logic wr_csr_b; // Write to control/status B this cycle
  logic wr_dis; // Write to input-disable register this cycle
  acc_byte_type wbyte; // Written byte
  acc_byte_type rd_mux; // Read value of the held address

  // ==========================================================
  // Comparator path
  logic cmp_sync_output; // Synchronised comparator output
  logic cmp_prev_ff; // Previous synchronised sample
  logic rise; // Rising output edge
  logic fall; // Falling output edge
  logic edge_event; // Edge matching the mode
  logic flag_clr; // Software or vector clears the flag

  acc_mux_if mux_if ();

  // ==========================================================
  // AHB-Lite address and data phase
  assign addr_take = hsel && htrans[1] && hready;
  assign hreadyout = !rd_wait_ff; // Only reads wait, writes go straight
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign wbyte = hwdata[7:0];
  assign wr_csr_a = wr_pend_ff && addr_ff == {22'h0, `ACC_IDX_CSR_A, 2'h0};
  assign wr_csr_b = wr_pend_ff && addr_ff == {22'h0, `ACC_IDX_CSR_B, 2'h0};
  assign wr_dis = wr_pend_ff
    && addr_ff == {22'h0, `ACC_IDX_DIG_IN_DIS, 2'h0};

  // Capture the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_wait_ff <= 1'b0;
      addr_ff <= 32'h0;
    end else begin
      wr_pend_ff <= addr_take && hwrite;
      // Read sits one cycle so a preceding write has landed
      rd_wait_ff <= addr_take && !hwrite;
      if (addr_take) begin
        addr_ff <= haddr;
      end
    end
  end

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    rd_mux = 8'h00;
    if (addr_ff == {22'h0, `ACC_IDX_CSR_A, 2'h0}) begin
      rd_mux = {pwr_off_ff, bandgap_ff, cmp_sync_output, flag_ff,
                irq_en_ff, borrow_ff, mode_ff};
    end else if (addr_ff == {22'h0, `ACC_IDX_CSR_B, 2'h0}) begin
      rd_mux = {hyst_en_ff, hyst_lvl_ff, 3'h0, insel_ff};
    end else if (addr_ff == {22'h0, `ACC_IDX_DIG_IN_DIS, 2'h0}) begin
      rd_mux = dig_in_dis_ff;
    end
  end

  // Read data register, loaded in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0;
    end else if (rd_wait_ff) begin
      hrdata_ff <= {24'h0, rd_mux};
    end
  end

  // ==========================================================
  // Control/status A writable fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_off_ff <= 1'b0;
      bandgap_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      borrow_ff <= 1'b0;
      mode_ff <= acc_mode_toggle;
    end else if (wr_csr_a) begin
      // Power bit takes effect whenever written
      pwr_off_ff <= wbyte[`ACC_A_PWR_OFF]; //RULE_06
      bandgap_ff <= wbyte[`ACC_A_BANDGAP]; //RULE_05
      irq_en_ff <= wbyte[`ACC_A_IRQ_EN]; //RULE_10
      borrow_ff <= wbyte[`ACC_A_BORROW]; //RULE_01
      mode_ff <= acc_irq_mode_type'(wbyte[`ACC_A_MODE_HI:`ACC_A_MODE_LO]);
    end
  end

  // Control/status B fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hyst_en_ff <= 1'b0;
      hyst_lvl_ff <= 1'b0;
      insel_ff <= 3'h0;
    end else if (wr_csr_b) begin
      hyst_en_ff <= wbyte[`ACC_B_HYST_EN]; //RULE_13
      hyst_lvl_ff <= wbyte[`ACC_B_HYST_LVL]; //RULE_13
      insel_ff <= wbyte[`ACC_B_INSEL_HI:`ACC_B_INSEL_LO];
    end
  end

  // Input-disable register and gated pin reads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dig_in_dis_ff <= `ACC_RST_DIG_IN_DIS;
      pin_read_ff <= 8'h00;
    end else begin
      if (wr_dis) begin
        dig_in_dis_ff <= wbyte;
      end
      // Disabled buffers read as zero
      pin_read_ff <= pin_digital_in & ~dig_in_dis_ff; //RULE_14
    end
  end

  // ==========================================================
  // Comparator output synchroniser
  acc_sync #(
    .WIDTH(1),
    .STAGES(`ACC_SYNC_STAGES)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(cmp_raw),
    .dout(cmp_sync_output) //RULE_07
  );

  // Previous sample for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_prev_ff <= 1'b0;
    end else begin
      cmp_prev_ff <= cmp_sync_output; //RULE_15
    end
  end

  assign rise = cmp_sync_output && !cmp_prev_ff; //RULE_15
  assign fall = !cmp_sync_output && cmp_prev_ff; //RULE_15

  // Edge against mode
  always_comb begin
    unique case (mode_ff) //RULE_11
      acc_mode_toggle: edge_event = rise || fall;
      acc_mode_falling: edge_event = fall;
      acc_mode_rising: edge_event = rise;
      acc_mode_reserved: edge_event = 1'b0; //RULE_15
    endcase
  end

  // ==========================================================
  // Event flag and interrupt
  assign flag_clr = irq_vector_taken || (wr_csr_a && wbyte[`ACC_A_FLAG]);

  // A new edge wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_ff <= 1'b0;
    end else if (edge_event) begin
      flag_ff <= 1'b1; //RULE_08
    end else if (flag_clr) begin
      flag_ff <= 1'b0; //RULE_09
    end
  end

  // Level request, masked by enable and global enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= flag_ff && irq_en_ff && global_irq_enable; //RULE_10
    end
  end
  assign irq = irq_ff;

  // ==========================================================
  // Selector and outputs
  assign mux_if.cmp_mux_borrow_enable = borrow_ff;
  assign mux_if.converter_enable = converter_enable;
  assign mux_if.converter_channel_select = converter_channel_select;
  assign mux_if.cmp_input_select = insel_ff;
  assign mux_if.cmp_bandgap_select = bandgap_ff;

  acc_in_mux u_mux (
    .hclk(hclk),
    .hresetn(hresetn),
    .mx(mux_if.sel)
  );

  assign pos_pin_sel = mux_if.pos_pin_sel_ff;
  assign pos_bandgap = mux_if.pos_bandgap_ff;
  assign neg_pin_sel = mux_if.neg_pin_sel_ff;
  assign neg_from_converter = mux_if.neg_from_conv_ff;
  assign neg_channel = mux_if.neg_channel_ff;
  assign cmp_power_off = pwr_off_ff;
  assign hysteresis_enable = hyst_en_ff;
  assign hysteresis_level = hyst_lvl_ff;
  assign pin_digital_read = pin_read_ff;
  assign digital_input_disable = dig_in_dis_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  power_write_a: assert property ( //RULE_06
    (wr_csr_a && wbyte[`ACC_A_PWR_OFF]) |=> cmp_power_off)
    else $error("power-off write not applied");
  sync_delay_a: assert property ( //RULE_07
    cmp_raw |-> ##2 cmp_sync_output)
    else $error("synchronised output late");
  rise_flag_a: assert property ( //RULE_08
    (rise && mode_ff == acc_mode_rising) |=> flag_ff)
    else $error("rising edge did not set flag");
  vector_clear_a: assert property ( //RULE_09
    (flag_ff && irq_vector_taken && !edge_event) |=> !flag_ff)
    else $error("vector did not clear flag");
  irq_mask_a: assert property ( //RULE_10
    (!irq_en_ff || !global_irq_enable) |=> !irq)
    else $error("masked request asserted");
  fall_mode_a: assert property ( //RULE_11
    (mode_ff == acc_mode_falling && rise && !flag_ff && !flag_clr)
      |=> !flag_ff)
    else $error("rising edge flagged in falling mode");
  hyst_write_a: assert property ( //RULE_13
    wr_csr_b |=> hysteresis_enable == $past(wbyte[`ACC_B_HYST_EN])
      && hysteresis_level == $past(wbyte[`ACC_B_HYST_LVL]))
    else $error("hysteresis bits not applied");
  pin_gate_a: assert property ( //RULE_14
    dig_in_dis_ff[0] |=> !pin_digital_read[0])
    else $error("disabled pin read not zero");
  reserved_quiet_a: assert property ( //RULE_15
    (mode_ff == acc_mode_reserved && !flag_ff) |=> !flag_ff)
    else $error("flag set in reserved mode");
  flag_set_c: cover property (edge_event ##1 flag_ff);
  irq_on_c: cover property (flag_ff && irq_en_ff ##1 irq);
  read_c: cover property (rd_wait_ff ##1 hreadyout);
endmodule
`default_nettype wire

// ---- bench/acc_core_model.sv ----
// Behavioural analog comparator core facing the control block.
// Assumes the bench sets pin_mv and ch_mv by hierarchical reference.
`timescale 1ns/1ps
`default_nettype none
module acc_core_model #(
  parameter int BANDGAP_MV = 1100
) (
  input wire logic hclk,
  input wire logic [2:0] pos_pin_sel,
  input wire logic pos_bandgap,
  input wire logic [2:0] neg_pin_sel,
  input wire logic neg_from_converter,
  input wire logic [5:0] neg_channel,
  input wire logic cmp_power_off,
  input wire logic hysteresis_enable,
  input wire logic hysteresis_level,
  output logic cmp_raw
);
  int pin_mv [3]; // Dedicated pin levels in millivolts
  int ch_mv [16]; // Converter channel levels
  int pos_mv; // Positive side level
  int neg_mv; // Negative side level
  int hyst_mv; // Dead band around the switch point

  // ==========================================================
  // Output moves on the falling edge, away from the sampling edge
  initial cmp_raw = 1'b0;
  always @(negedge hclk) begin
    pos_mv = pos_bandgap ? BANDGAP_MV : 0;
    neg_mv = neg_from_converter ? ch_mv[neg_channel[3:0]] : 0;
    for (int k = 0; k < 3; k++) begin
      if (pos_pin_sel[k]) pos_mv = pin_mv[k];
      if (neg_pin_sel[k]) neg_mv = pin_mv[k];
    end
    hyst_mv = !hysteresis_enable ? 0 : (hysteresis_level ? 50 : 20);
    // Unpowered core gives no valid level, so it wanders
    if (cmp_power_off) begin
      cmp_raw <= ~cmp_raw;
    end else if (pos_mv > neg_mv + hyst_mv) begin
      cmp_raw <= 1'b1;
    end else if (pos_mv < neg_mv - hyst_mv) begin
      cmp_raw <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_analog_comparator_control.sv ----
// Self-checking bench for the comparator control block.
// Assumes the design package, header and the core model are compiled first.
`include "acc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_analog_comparator_control;
  import acc_pkg::*;
  localparam logic [31:0] ADR_D = 32'(`ACC_IDX_DIG_IN_DIS) << 2;
  localparam logic [31:0] ADR_A = 32'(`ACC_IDX_CSR_A) << 2;
  localparam logic [31:0] ADR_B = 32'(`ACC_IDX_CSR_B) << 2;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, cmp_raw;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, pos_pin_sel, neg_pin_sel;
  logic converter_enable, global_irq_enable, irq_vector_taken;
  logic cmp_power_off, hysteresis_enable, hysteresis_level;
  logic pos_bandgap, neg_from_converter;
  logic [5:0] converter_channel_select, neg_channel;
  logic [7:0] pin_digital_in, pin_digital_read, digital_input_disable;
  wire logic hready;
  int fail_count, samples_checked, seed;
  int pt [8] = '{0, 0, 1, 1, 2, 2, 2, 2}; // Positive pin by code
  int nt [8] = '{1, 2, 0, 2, 0, 1, 1, 1}; // Negative pin by code

  assign hready = hreadyout; // Single slave drives bus ready
  acc_top u_acc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .converter_enable(converter_enable),
    .converter_channel_select(converter_channel_select),
    .global_irq_enable(global_irq_enable),
    .irq_vector_taken(irq_vector_taken), .irq(irq), .cmp_raw(cmp_raw),
    .cmp_power_off(cmp_power_off), .hysteresis_enable(hysteresis_enable),
    .hysteresis_level(hysteresis_level), .pos_pin_sel(pos_pin_sel),
    .pos_bandgap(pos_bandgap), .neg_pin_sel(neg_pin_sel),
    .neg_from_converter(neg_from_converter), .neg_channel(neg_channel),
    .pin_digital_in(pin_digital_in), .pin_digital_read(pin_digital_read),
    .digital_input_disable(digital_input_disable));
  acc_core_model u_acc_core_model (.hclk(hclk), .pos_pin_sel(pos_pin_sel),
    .pos_bandgap(pos_bandgap), .neg_pin_sel(neg_pin_sel),
    .neg_from_converter(neg_from_converter), .neg_channel(neg_channel),
    .cmp_power_off(cmp_power_off), .hysteresis_enable(hysteresis_enable),
    .hysteresis_level(hysteresis_level), .cmp_raw(cmp_raw));

  // ==========================================================
  // Clock, verdict and shared bus tasks
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Waits as long as the slave needs; only the watchdog ends a stuck bus
  task automatic wait_ready();
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
  endtask

  // One single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, {24'h0, d}, r);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, {24'h0, e});
    check(hresp, 1'b0); // Response always OKAY
  endtask

  // Expected csr A with irq enabled, borrow off, reference off
  function automatic logic [7:0] a_exp(input logic s, input logic f,
                                       input int m);
    return {2'b00, s, f, 1'b1, 1'b0, 2'(m)};
  endfunction

  // Watchdog: the full run needs well under 5000 cycles
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] d, din, ex;
    logic [5:0] ch;
    logic [2:0] c;
    logic bo, cen, bg, f;
    seed = 32'hee1ee43e;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, irq_vector_taken, converter_enable} = '0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    global_irq_enable = 1'b1;
    converter_channel_select = 6'h00;
    pin_digital_in = 8'h00;
    tick(3);
    hresetn <= 1'b1;
    // Reset values, unmapped place, read-only bits
    rchk(ADR_D, 8'h00);
    rchk(ADR_A, 8'h00);
    rchk(ADR_B, 8'h00);
    wr(32'h10, 8'hFF);
    rchk(32'h10, 8'h00);
    wr(ADR_B, 8'hFF);
    rchk(ADR_B, 8'hC7);
    check({hysteresis_enable, hysteresis_level}, 2'h3);
    wr(ADR_A, 8'h80);
    tick(1);
    check(cmp_power_off, 1'b1);
    wr(ADR_A, 8'h00);
    tick(1);
    check(cmp_power_off, 1'b0);
    // Input disable masks the pin reads
    repeat (2) begin
      d = 8'($random(seed));
      din = 8'($random(seed));
      pin_digital_in <= din;
      wr(ADR_D, d);
      tick(2);
      check(pin_digital_read, din & ~d);
      rchk(ADR_D, d);
      check(digital_input_disable, d);
    end
    // Every input code under every borrow and converter state
    for (int i = 0; i < 32; i++) begin
      c = i[2:0];
      bo = i[3];
      cen = i[4];
      bg = 1'($random(seed));
      ch = 6'(($random(seed) & 32'h7FFF) % 11);
      converter_enable <= cen;
      converter_channel_select <= ch;
      wr(ADR_B, {5'h00, c});
      wr(ADR_A, {1'b0, bg, 3'b000, bo, 2'b00});
      tick(2);
      ex[7:5] = bg ? 3'h0 : 3'(1 << pt[c]);
      ex[4] = bg;
      ex[3:1] = (bo && !cen) ? 3'h0 : 3'(1 << nt[c]);
      ex[0] = bo && !cen;
      check({pos_pin_sel, pos_bandgap, neg_pin_sel, neg_from_converter},
            ex);
      if (bo && !cen) check(neg_channel, ch);
    end
    // Edge modes: pin0 against pin1 at 500 mV
    converter_enable <= 1'b0;
    wr(ADR_B, 8'h00);
    wr(ADR_A, 8'h00);
    u_acc_core_model.pin_mv[1] = 500;
    tick(6);
    for (int m = 0; m < 4; m++) begin
      // Enable dropped under the old mode first, stray flag cleared after
      wr(ADR_A, 8'(m == 0 ? 0 : m - 1));
      wr(ADR_A, 8'(m));
      wr(ADR_A, 8'h18 | 8'(m));
      u_acc_core_model.pin_mv[0] = 600;
      tick(6);
      f = (m == 0 || m == 3);
      rchk(ADR_A, a_exp(1'b1, f, m));
      check(irq, f);
      global_irq_enable <= 1'b0;
      wr(ADR_A, 8'h08 | 8'(m));
      tick(2);
      check(irq, 1'b0);
      rchk(ADR_A, a_exp(1'b1, f, m));
      global_irq_enable <= 1'b1;
      wr(ADR_A, 8'h18 | 8'(m));
      tick(2);
      rchk(ADR_A, a_exp(1'b1, 1'b0, m));
      check(irq, 1'b0);
      u_acc_core_model.pin_mv[0] = 400;
      tick(6);
      f = (m == 0 || m == 2);
      rchk(ADR_A, a_exp(1'b0, f, m));
      irq_vector_taken <= 1'b1;
      tick(1);
      irq_vector_taken <= 1'b0;
      tick(2);
      rchk(ADR_A, a_exp(1'b0, 1'b0, m));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
